/* File: verilog/fault_status_monitor_defines.svh */
// offsets, field positions, reset values and timing counts of the fault supervisor
`ifndef FAULT_STATUS_MONITOR_DEFINES_SVH
`define FAULT_STATUS_MONITOR_DEFINES_SVH
`define OFS_CLEAR_FAULTS 8'h03
`define OFS_PD_STATUS 8'h21
`define OFS_STATUS_BYTE 8'h78
`define BIT_BUSY 7
`define BIT_OFF 6
`define BIT_OV 5
`define BIT_OC 4
`define BIT_INPUT 3
`define BIT_TEMP 2
`define BIT_LOGIC 1
`define BIT_OTHER 0
`define BIT_PD_ILIM 0
`define LATCH_MASK 8'h3E
`define STATUS_RST 8'h00
`define BOOTSTRAP_UNDERVOLTAGE_CYCLES 8'h08
`define HICCUP_OFF_CYCLES 16'h0400
`endif

/* File: verilog/fault_status_monitor_pkg.sv */
// types shared by the fault supervisor
package fault_status_monitor_pkg;
	typedef struct packed {
		logic thermal_shutdown;
		logic thermal_warning;
		logic peak_current_trip;
		logic feedback_overvoltage_guard;
		logic absolute_overvoltage_guard;
		logic input_overvoltage_guard;
		logic input_detect_low;
		logic bootstrap_undervoltage;
		logic power_good;
		logic avg_current_limit_trip;
	} cond_t;
	typedef struct packed {
		logic hiccup_enable;
		logic absolute_ov_enable;
		logic input_protect_enable;
		logic input_regulation_enable;
		logic avg_limit_enable;
		logic irq_pin_mode_select;
		logic forced_pwm_request;
	} cfg_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	typedef enum logic [2:0] {
		ST_BOOT,
		ST_CRC,
		ST_OFF,
		ST_RUN,
		ST_HICCUP,
		ST_HOLD
	} conv_state_t;
endpackage

/* File: verilog/fault_status_monitor.sv */
// status byte, fault latching, fault pin and protection sequencing
//
// Summary of operation
// - busy bit high while another internal agent uses the registers; valid after start-up
// - off bit when output below power good or disabled; valid after start-up
// - output overvoltage bit latches on either guard until cleared
// - overcurrent bit latches on peak current trip until cleared
// - input bit latches on input detect low until cleared
// - temperature bit latches on shutdown or warning until cleared
// - internal logic fault bit set on checksum mismatch
// - average limit flag low when disabled, high at threshold, PD byte tracks it
// - mode 0: fault pin asserted for every reported fault
// - mode 0: pin released during hiccup or once fault disappears
// - mode 1: pin toggles on any change of status or PD inputs
// - clear by any access to fault clear, or write-one to status byte
// - thermal shutdown halts conversion, resumes after temperature recovers
// - hiccup enabled: peak trip stops then restarts; disabled: no action
// - feedback guard never stops, masked in micro-sleep, off in soft-start
// - absolute guard tristates switch nodes until output falls; can be disabled
// - input guard blocks forced PWM, forward current only; can be disabled
// - input regulation needs both enables and pauses without forced PWM
// - bootstrap undervoltage: stop after count, or refresh then stop
// - checksum mismatch after boot keeps converter in hold state
`include "fault_status_monitor_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module fault_status_monitor
	import fault_status_monitor_pkg::*;
#(
	parameter logic [7:0] BOOTSTRAP_UNDERVOLTAGE_CYCLES = `BOOTSTRAP_UNDERVOLTAGE_CYCLES,
	parameter logic [15:0] HICCUP_OFF_CYCLES = `HICCUP_OFF_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire cond_t cond,
	input wire cfg_t cfg,
	input wire logic internal_agent_busy,
	input wire logic system_enable,
	input wire logic soft_start_active,
	input wire logic internal_feedback_sel,
	input wire logic micro_sleep,
	input wire logic power_save_mode,
	input wire logic switch_cycle,
	input wire logic nvm_boot_done,
	input wire logic crc_mismatch,
	output logic converter_run,
	output logic switch_nodes_hiz,
	output logic forced_pwm,
	output logic forward_only,
	output logic input_voltage_regulation,
	output logic boot_refresh,
	output logic avg_current_limit_active,
	output logic fault_or_irq_pin_o,
	output logic fault_or_irq_pin_oe_n
);
	conv_state_t state_r;
	logic [7:0] status_r;
	logic [7:0] pd_status_byte;
	logic [7:0] inst_status;
	logic [7:0] prev_inst_r;
	logic [7:0] prev_pd_r;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;
	logic [15:0] hiccup_cnt_r;
	logic [7:0] buv_cnt_r;
	logic started;
	logic ov_fb_valid;
	logic ov_abs_valid;
	logic buv_stop;
	logic irq_r;
	logic restart_r;
	logic clear_all;
	logic status_wr;

	assign started = (state_r == ST_RUN) || (state_r == ST_HICCUP) || (state_r == ST_HOLD);
	// feedback guard only reports, never stops the converter
	assign ov_fb_valid = cond.feedback_overvoltage_guard && !micro_sleep && !soft_start_active
		&& !internal_feedback_sel;
	assign ov_abs_valid = cond.absolute_overvoltage_guard && cfg.absolute_ov_enable;
	assign avg_current_limit_active = cfg.avg_limit_enable && cond.avg_current_limit_trip;
	assign pd_status_byte = {7'h00, avg_current_limit_active};

	always_comb begin
		inst_status = 8'h00;
		inst_status[`BIT_BUSY] = started && internal_agent_busy;
		inst_status[`BIT_OFF] = started && (!cond.power_good || !system_enable
			|| !converter_run);
		inst_status[`BIT_OV] = ov_fb_valid || ov_abs_valid;
		inst_status[`BIT_OC] = cond.peak_current_trip;
		inst_status[`BIT_INPUT] = cond.input_detect_low;
		inst_status[`BIT_TEMP] = cond.thermal_shutdown || cond.thermal_warning;
		inst_status[`BIT_LOGIC] = crc_mismatch && (state_r == ST_CRC || state_r == ST_HOLD);
	end

	assign clear_all = (reg_req.wr || reg_req.rd) && reg_req.addr == `OFS_CLEAR_FAULTS;
	assign status_wr = reg_req.wr && reg_req.addr == `OFS_STATUS_BYTE;

	always_comb begin
		set_vec = inst_status & `LATCH_MASK;
		clr_vec = 8'h00;
		if (clear_all) begin
			clr_vec = `LATCH_MASK;
		end else if (status_wr) begin
			clr_vec = reg_req.wdata & `LATCH_MASK;
		end
	end

	// latched bits: a set in the clear cycle wins, a live condition re-sets
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			status_r <= `STATUS_RST;
		end else begin
			status_r <= (status_r & ~clr_vec) | set_vec
				| (inst_status & ~(`LATCH_MASK));
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				`OFS_STATUS_BYTE: reg_rdata <= status_r;
				`OFS_PD_STATUS: reg_rdata <= pd_status_byte;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// converter sequencing
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_BOOT;
		end else begin
			case (state_r)
				ST_BOOT: begin
					if (nvm_boot_done) begin
						state_r <= ST_CRC;
					end
				end
				ST_CRC: begin
					state_r <= crc_mismatch ? ST_HOLD : ST_OFF;
				end
				ST_OFF: begin
					if (system_enable && !cond.thermal_shutdown) begin
						state_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!system_enable || cond.thermal_shutdown || buv_stop) begin
						state_r <= ST_OFF;
					end else if (cfg.hiccup_enable && cond.peak_current_trip) begin
						state_r <= ST_HICCUP;
					end
				end
				ST_HICCUP: begin
					if (hiccup_cnt_r == HICCUP_OFF_CYCLES) begin
						state_r <= ST_OFF;
					end
				end
				ST_HOLD: state_r <= ST_HOLD;
				default: state_r <= ST_BOOT;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hiccup_cnt_r <= 16'h0000;
		end else if (state_r == ST_HICCUP) begin
			hiccup_cnt_r <= hiccup_cnt_r + 16'h0001;
		end else begin
			hiccup_cnt_r <= 16'h0000;
		end
	end

	// bootstrap undervoltage counts switching or refresh cycles
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			buv_cnt_r <= 8'h00;
		end else if (state_r != ST_RUN || !cond.bootstrap_undervoltage) begin
			buv_cnt_r <= 8'h00;
		end else if (switch_cycle && buv_cnt_r != BOOTSTRAP_UNDERVOLTAGE_CYCLES) begin
			buv_cnt_r <= buv_cnt_r + 8'h01;
		end
	end
	assign buv_stop = cond.bootstrap_undervoltage && buv_cnt_r == BOOTSTRAP_UNDERVOLTAGE_CYCLES;
	assign boot_refresh = (state_r == ST_RUN) && power_save_mode && cond.bootstrap_undervoltage
		&& !buv_stop;

	assign converter_run = (state_r == ST_RUN) && !ov_abs_valid;
	assign switch_nodes_hiz = !converter_run;
	assign forward_only = cfg.input_protect_enable && cond.input_overvoltage_guard;
	assign forced_pwm = cfg.forced_pwm_request && !power_save_mode && !forward_only;
	assign input_voltage_regulation = cfg.input_regulation_enable && cfg.input_protect_enable
		&& forced_pwm && converter_run;

	// restart flag follows the hiccup state one cycle late and lets mode 0 release the pin during hiccup
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			restart_r <= 1'b0;
		end else begin
			restart_r <= (state_r == ST_HICCUP);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_inst_r <= 8'h00;
			prev_pd_r <= 8'h00;
		end else begin
			prev_inst_r <= inst_status;
			prev_pd_r <= pd_status_byte;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_r <= 1'b0;
		end else if (cfg.irq_pin_mode_select) begin
			if (inst_status != prev_inst_r || pd_status_byte != prev_pd_r) begin
				irq_r <= ~irq_r;
			end
		end else begin
			irq_r <= |(inst_status & `LATCH_MASK) && !restart_r;
		end
	end

	// open drain: drive low when asserted (mode 0) or toggle state high (mode 1)
	assign fault_or_irq_pin_o = 1'b0;
	assign fault_or_irq_pin_oe_n = !irq_r;
endmodule // fault_status_monitor
`default_nettype wire

/* File: test/fault_status_monitor_props.sv */
// port assertions of the fault supervisor
`timescale 1ns/100ps
`default_nettype none
module fault_status_monitor_props
	import fault_status_monitor_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire cond_t cond,
	input wire cfg_t cfg,
	input wire logic converter_run,
	input wire logic switch_nodes_hiz,
	input wire logic forced_pwm,
	input wire logic input_voltage_regulation,
	input wire logic avg_current_limit_active,
	input wire logic fault_or_irq_pin_oe_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_pd_track: assert property (reg_req.rd && reg_req.addr == 8'h21
		|=> reg_rdata[0] == $past(avg_current_limit_active)) else $error("pd byte stale");
	a_avg_gate: assert property (!cfg.avg_limit_enable
		|-> !avg_current_limit_active) else $error("avg flag while off");
	a_oc_latch: assert property (cond.peak_current_trip ##1
		(reg_req.rd && reg_req.addr == 8'h78) |=> reg_rdata[4]) else $error("oc lost");
	a_tsd_stop: assert property (cond.thermal_shutdown
		|=> !converter_run) else $error("run in tsd");
	a_hiccup_stop: assert property (cfg.hiccup_enable && cond.peak_current_trip
		&& converter_run |=> !converter_run) else $error("no hiccup");
	a_abs_hiz: assert property (cfg.absolute_ov_enable && converter_run
		&& cond.absolute_overvoltage_guard |-> switch_nodes_hiz) else $error("no hiz");
	a_ivp_block: assert property (cfg.input_protect_enable
		&& cond.input_overvoltage_guard |-> !forced_pwm) else $error("forced_pwm in ivp");
	a_ivr_gate: assert property (input_voltage_regulation |->
		cfg.input_protect_enable && cfg.input_regulation_enable && forced_pwm) else $error("ivr");
	a_pin_fault: assert property (!cfg.irq_pin_mode_select && cond.input_detect_low
		&& converter_run ##1 !cfg.irq_pin_mode_select |-> !fault_or_irq_pin_oe_n)
		else $error("pin not low");
	a_irq_toggle: assert property (cfg.irq_pin_mode_select && $changed(avg_current_limit_active)
		|=> $changed(fault_or_irq_pin_oe_n)) else $error("no toggle");
endmodule // fault_status_monitor_props
bind fault_status_monitor fault_status_monitor_props fault_status_monitor_props_i (.*);
`default_nettype wire

/* File: test/pd_controller_model.sv */
// register-access model of the external controller
`timescale 1ns/100ps
`default_nettype none
module pd_controller_model
	import fault_status_monitor_pkg::*;
(
	input wire logic clk,
	input wire logic busy,
	output var reg_req_t reg_req
);
	initial reg_req = '0;
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_req <= '{wr: w & !busy, rd: !w, addr: a, wdata: d};
		@(negedge clk);
		reg_req <= '{wr: 0, rd: 0, addr: ~a, wdata: ~d};
	endtask
endmodule // pd_controller_model
`default_nettype wire

/* File: test/fault_status_monitor_tb.sv */
// self-checking bench of the fault supervisor
`timescale 1ns/100ps
`default_nettype none
module fault_status_monitor_tb;
	import fault_status_monitor_pkg::*;
	logic clk = 0, sys_rst = 1, internal_agent_busy = 0, system_enable = 0, nvm_boot_done = 0;
	logic crc_mismatch = 0, soft_start_active = 0, internal_feedback_sel = 0, micro_sleep = 0;
	logic power_save_mode = 0, switch_cycle = 0;
	cond_t cond = '0;
	cfg_t cfg = '0;
	reg_req_t reg_req;
	logic [7:0] reg_rdata, e;
	logic converter_run, switch_nodes_hiz, forced_pwm, forward_only, input_voltage_regulation;
	logic boot_refresh, avg_current_limit_active, fault_or_irq_pin_o, fault_or_irq_pin_oe_n;
	int fails = 0, n_tests = 0, cyc = 0;
	int lb[4] = '{8, 7, 5, 3};
	int sb[4] = '{2, 4, 5, 3};
	fault_status_monitor #(.BOOTSTRAP_UNDERVOLTAGE_CYCLES(8'h02), .HICCUP_OFF_CYCLES(16'h0004))
		fault_status_monitor_i (.*);
	pd_controller_model pd_controller_model_i (.clk, .busy(internal_agent_busy), .reg_req);
	initial forever #50 clk = ~clk;
	always @(posedge clk) if (++cyc == 20000) begin
		fails++;
		summarize();
	end
	task automatic chk(input string s, input logic [7:0] x, input logic [7:0] y);
		n_tests++;
		if (x !== y) begin
			fails++;
			$display("ERROR %s expected %h seen %h", s, x, y);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
		pd_controller_model_i.acc(0, a, 8'h00);
		chk("rdata", x, reg_rdata & m);
	endtask
	// 0 write clear reg, 1 read clear reg, 2 write-one status
	task automatic clr(input int k, input logic [7:0] v);
		if (k == 1) pd_controller_model_i.acc(0, 8'h03, 8'h00);
		else pd_controller_model_i.acc(1, k ? 8'h78 : 8'h03, v);
	endtask
	function automatic logic [7:0] prot(input cfg_t c, input logic iv);
		logic fo;
		fo = c.input_protect_enable & iv;
		return {5'h00, fo, c.forced_pwm_request & !fo,
			c.input_regulation_enable & c.input_protect_enable & c.forced_pwm_request & !fo};
	endfunction
	task automatic summarize();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		void'($urandom(78));
		repeat (12) @(posedge clk);
		@(negedge clk) sys_rst = 0;
		rdchk(8'h78, 8'hFF, 8'h00);
		@(negedge clk) {nvm_boot_done, system_enable, cond.power_good} = 3'h7;
		cfg.absolute_ov_enable = 1;
		repeat (4) @(negedge clk);
		chk("run", 8'h01, {7'h00, converter_run});
		{internal_agent_busy, cond.power_good} = 2'h2;
		rdchk(8'h78, 8'hC0, 8'hC0);
		{internal_agent_busy, cond.power_good} = 2'h1;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk) cond[lb[i]] = 1;
			@(negedge clk) cond = cond & 10'h002;
			e = 8'h01 << sb[i];
			rdchk(8'h78, 8'h3E, e);
			clr(i % 3, e);
			rdchk(8'h78, 8'h3E, 8'h00);
		end
		chk("no hiccup", 8'h01, {7'h00, converter_run});
		cond.input_detect_low = 1;
		clr(0, 8'h00);
		rdchk(8'h78, 8'h3E, 8'h08);
		chk("pin", 8'h00, {7'h00, fault_or_irq_pin_oe_n});
		cond.input_detect_low = 0;
		clr(2, 8'h08);
		chk("pin release", 8'h01, {fault_or_irq_pin_o, 6'h00, fault_or_irq_pin_oe_n});
		system_enable = 0;
		repeat (3) @(negedge clk);
		cfg.irq_pin_mode_select = 1;
		system_enable = 1;
		repeat (40) begin
			@(negedge clk) {cfg.avg_limit_enable, cond.avg_current_limit_trip,
				cfg.input_protect_enable, cfg.input_regulation_enable, cfg.forced_pwm_request,
				cond.input_overvoltage_guard, micro_sleep, switch_cycle} = 8'($urandom);
			e = {7'h00, cfg.avg_limit_enable & cond.avg_current_limit_trip};
			rdchk(8'h21, 8'h01, e);
			chk("protect", prot(cfg, cond.input_overvoltage_guard), {5'h00, forward_only, forced_pwm, input_voltage_regulation});
		end
		@(negedge clk) {cfg.hiccup_enable, cond.peak_current_trip} = 2'h3;
		@(negedge clk) cond.peak_current_trip = 0;
		chk("hiccup stop", 8'h00, {7'h00, converter_run});
		repeat (10) @(negedge clk);
		chk("hiccup restart", 8'h01, {7'h00, converter_run});
		cond.thermal_shutdown = 1;
		@(negedge clk) chk("tsd stop", 8'h00, {7'h00, converter_run});
		cond.thermal_shutdown = 0;
		repeat (2) @(negedge clk);
		chk("tsd resume", 8'h01, {7'h00, converter_run});
		{power_save_mode, cond.bootstrap_undervoltage} = 2'h3;
		@(negedge clk) switch_cycle = 1;
		@(negedge clk) switch_cycle = 0;
		chk("refresh", 8'h01, {7'h00, boot_refresh});
		@(negedge clk) switch_cycle = 1;
		@(negedge clk) switch_cycle = 0;
		@(negedge clk);
		chk("buv stop", 8'h00, {7'h00, converter_run});
		{power_save_mode, cond.bootstrap_undervoltage} = 2'h0;
		{sys_rst, crc_mismatch} = 2'h3;
		@(negedge clk) sys_rst = 0;
		repeat (20) @(negedge clk);
		chk("crc hold", 8'h00, {7'h00, converter_run});
		rdchk(8'h78, 8'h02, 8'h02);
		summarize();
	end
endmodule // fault_status_monitor_tb
`default_nettype wire
